// file: dv/video_sync_processor_tb.sv
// self-checking bench for the video sync processor
`timescale 1ns/1ps
`default_nettype none
module video_sync_processor_tb
  import vsp_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic hl = 1'b0;
  logic vl = 1'b0;
  logic cl = 1'b0;
  logic h_in, v_in, c_in, hsync_o, vsync_o, clamp_o;
  int fails = 0;
  int checks_done = 0;
  // ****************************************
  // clock, design and source
  // ****************************************
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  vsp_sync_processor u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat),
    .dat_o(rdat), .ack_o(ack), .hsync_in_i(h_in), .csync_in_i(c_in),
    .vsync_in_i(v_in), .hsync_o(hsync_o), .vsync_o(vsync_o),
    .clamp_o(clamp_o));
  vsp_sync_source u_src (.clk_i(clk_i), .h_lvl_i(hl), .v_lvl_i(vl),
    .c_lvl_i(cl), .hsync_o(h_in), .vsync_o(v_in), .csync_o(c_in));
  // ****************************************
  // tasks
  // ****************************************
  task automatic final_report;
    if (fails == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] i,
                    input logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    logic [31:0] r;
    wb(1'b1, i, d, r);
  endtask
  task automatic rdc(input logic [7:0] i, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, i, 8'h00, r);
    chk_reg(r, exp);
  endtask
  // count active clamp cycles after one trigger edge
  task automatic clamp_case(input logic [1:0] s, input logic p,
                            input logic q);
    int cnt;
    cnt = 0;
    hl <= p;
    wr(SYNC_CONTROL_ONE_IDX, {s, p, q, 4'h0});
    tick(12);
    hl <= ~p;
    repeat (24)
    begin
      @(posedge clk_i);
      if (clamp_o === q)
        cnt++;
    end
    chk_reg(32'(cnt), s == 2'h0 ? 32'h0 : 32'h1 << s);
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    #1600000;
    fails++;
    final_report;
  end
  initial
  begin
    tick(8);
    rst_i <= 1'b0;
    tick(1);
    rdc(SYNC_CONTROL_ZERO_IDX, 32'h0);
    rdc(SYNC_CONTROL_ONE_IDX, 32'h0);
    chk_bit(clamp_o, 1'b1);
    wr(8'h10, 8'hFF);
    rdc(8'h10, 32'h0);
    wr(SYNC_CONTROL_ZERO_IDX, 8'h1F);
    rdc(SYNC_CONTROL_ZERO_IDX, 32'h0);
    wr(SYNC_CONTROL_ONE_IDX, 8'h03);
    rdc(SYNC_CONTROL_ONE_IDX, 32'h0);
    // source select, inversions
    hl <= 1'b1;
    vl <= 1'b1;
    tick(4);
    chk_bit(hsync_o, 1'b1);
    chk_bit(vsync_o, 1'b1);
    wr(SYNC_CONTROL_ONE_IDX, 8'h08);
    tick(3);
    chk_bit(vsync_o, 1'b0);
    wr(SYNC_CONTROL_ZERO_IDX, 8'h80);
    tick(3);
    chk_bit(hsync_o, 1'b0);
    wr(SYNC_CONTROL_ONE_IDX, 8'h04);
    tick(3);
    chk_bit(hsync_o, 1'b1);
    wr(SYNC_CONTROL_ONE_IDX, 8'h00);
    // integrator on composite input
    wr(SYNC_CONTROL_ZERO_IDX, 8'hA0);
    tick(80);
    cl <= 1'b1;
    tick(12);
    // twelve edges of high input give six sampling ticks
    rdc(SYNC_CONTROL_ZERO_IDX, 32'hA6);
    chk_bit(rdat[4:0] inside {[5'h01:5'h0A]}, 1'b1);
    tick(80);
    rdc(SYNC_CONTROL_ZERO_IDX, 32'hBF);
    chk_bit(vsync_o, 1'b1);
    chk_bit(hsync_o, 1'b1);
    wr(SYNC_CONTROL_ZERO_IDX, 8'hE0);
    tick(3);
    chk_bit(hsync_o, 1'b0);
    wr(SYNC_CONTROL_ZERO_IDX, 8'hA0);
    cl <= 1'b0;
    tick(16);
    chk_bit(vsync_o, 1'b1);
    tick(80);
    rdc(SYNC_CONTROL_ZERO_IDX, 32'hA0);
    chk_bit(vsync_o, 1'b0);
    // clamp: every width, porch and polarity
    wr(SYNC_CONTROL_ZERO_IDX, 8'h00);
    for (int k = 0; k < 16; k++)
      clamp_case(2'(k >> 2), k[1], k[0]);
    // polarity detection
    hl <= 1'b0;
    vl <= 1'b1;
    wr(SYNC_CONTROL_ONE_IDX, 8'h00);
    tick(33000);
    rdc(SYNC_CONTROL_ONE_IDX, 32'h01);
    vl <= 1'b0;
    tick(33000);
    rdc(SYNC_CONTROL_ONE_IDX, 32'h03);
    final_report;
  end
endmodule
`default_nettype wire

// file: dv/vsp_sync_source.sv
// model of the sync sources that feed the processor
`timescale 1ns/1ps
`default_nettype none
module vsp_sync_source
  import vsp_pkg::*;
(
  input wire logic clk_i,  // oscillator clock
  input wire logic h_lvl_i, // wanted horizontal level
  input wire logic v_lvl_i, // wanted vertical level
  input wire logic c_lvl_i, // wanted composite level
  output logic hsync_o,     // separate horizontal sync
  output logic vsync_o,     // separate vertical sync
  output logic csync_o      // composite sync
);
  // ****************************************
  // source lines
  // ****************************************
  // lines change one cycle after the request, like a re-timed source
  // horizontal line never carries composite, so its polarity holds
  always_ff @(posedge clk_i)
  begin
    hsync_o <= h_lvl_i;
    vsync_o <= v_lvl_i;
    csync_o <= c_lvl_i;
  end
endmodule
`default_nettype wire

// file: inc/vsp_pkg.sv
// constants and types for the video sync processor
//
// What this block does
// - sync select picks separate or composite horizontal
// - blank horizontal sync during vertical extraction if enabled
// - vertical output from pin or integrator compare
// - integrator counts up high, down low, saturates
// - compare output sets at ones, clears at zeros
// - integrator value readable in low five bits
// - clamp select: off, two, four, eight periods
// - porch bit picks rising or falling trigger edge
// - clamp polarity bit picks negative or positive pulse
// - vertical invert bit inverts vertical output
// - horizontal invert bit inverts horizontal output
// - polarity bits from sixteen ticks of divided clock
// - vertical polarity bit settles after sixteen ticks
package vsp_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] SYNC_CONTROL_ZERO_IDX = 8'hED;
  localparam logic [7:0] SYNC_CONTROL_ONE_IDX = 8'hEE;
  localparam logic [7:0] SYNC_CONTROL_ZERO_RST = 8'h00;
  localparam logic [7:0] SYNC_CONTROL_ONE_RST = 8'h00;

  // field positions, sync_control_zero
  localparam int INPUT_SOURCE_SELECT_BIT = 7;
  localparam int HBLANK_ENABLE_BIT = 6;
  localparam int VERTICAL_OUTPUT_SOURCE_BIT = 5;
  localparam int INTEG_W = 5;

  // field positions, sync_control_one
  localparam int CLAMP_SEL_HI_BIT = 7;
  localparam int CLAMP_SEL_LO_BIT = 6;
  localparam int PORCH_MODE_BIT = 5;
  localparam int CLAMP_POLARITY_BIT = 4;
  localparam int VERTICAL_OUTPUT_INVERT_BIT = 3;
  localparam int HORIZONTAL_OUTPUT_INVERT_BIT = 2;
  localparam int VPOL_BIT = 1;
  localparam int HPOL_BIT = 0;

  // integrator limits
  localparam logic [4:0] INTEG_MAX = 5'h1F;
  localparam logic [4:0] INTEG_MIN = 5'h00;

  // clock and divided rates
  localparam int CLK_PERIOD_NS = 20;
  localparam int SAMPLE_DIV = 2;
  localparam int POL_TIMER_DIV = 1000;
  localparam logic [9:0] POL_TIMER_LAST = 10'(POL_TIMER_DIV - 1);
  localparam logic [3:0] POL_WINDOW_LAST = 4'hF;
  localparam logic [4:0] POL_HALF = 5'h08;

  // clamp widths in oscillator periods, less one
  localparam logic [2:0] CLAMP_W2_LAST = 3'h1;
  localparam logic [2:0] CLAMP_W4_LAST = 3'h3;
  localparam logic [2:0] CLAMP_W8_LAST = 3'h7;

  typedef enum logic {CLAMP_IDLE, CLAMP_PULSE} vsp_clamp_state_type;

endpackage

// file: rtl/vsp_polarity.sv
// sync polarity detector over a window of timer ticks
`timescale 1ns/1ps
`default_nettype none
module vsp_polarity
  import vsp_pkg::*;
(
  input wire logic clk_i,   // system clock
  input wire logic rst_i,   // synchronous reset
  input wire logic tick_i,  // polarity timer tick
  input wire logic level_i, // sync input level
  output logic polarity_o   // 1 positive, 0 negative
);

  logic [3:0] tick_cnt;
  logic [4:0] high_cnt;
  wire [4:0] high_total = high_cnt + {4'h0, level_i};
  wire window_end = tick_i && (tick_cnt == POL_WINDOW_LAST);

  // a short active phase means the pulse level is its active level
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tick_cnt <= 4'h0;
      high_cnt <= 5'h00;
      polarity_o <= 1'b0;
    end
    else if (tick_i)
    begin
      tick_cnt <= tick_cnt + 4'h1;
      high_cnt <= window_end ? 5'h00 : high_total;
      if (window_end)
      begin
        polarity_o <= (high_total < POL_HALF);
      end
    end
  end

endmodule
`default_nettype wire

// file: rtl/vsp_sync_processor.sv
// sync processor top: separation, output shaping, clamp, registers
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module vsp_sync_processor
  import vsp_pkg::*;
(
  input wire logic clk_i,         // oscillator clock, 50 MHz
  input wire logic rst_i,         // synchronous reset, high
  input wire logic cyc_i,         // wishbone cycle
  input wire logic stb_i,         // wishbone strobe
  input wire logic we_i,          // wishbone write enable
  input wire logic [9:0] adr_i,   // wishbone byte address
  input wire logic [3:0] sel_i,   // wishbone byte selects
  input wire logic [31:0] dat_i,  // wishbone write data
  output logic [31:0] dat_o,      // wishbone read data
  output logic ack_o,             // wishbone acknowledge
  input wire logic hsync_in_i,    // separate horizontal sync
  input wire logic csync_in_i,    // composite sync
  input wire logic vsync_in_i,    // separate vertical sync
  output logic hsync_o,           // horizontal sync out
  output logic vsync_o,           // vertical sync out
  output logic clamp_o            // clamp pulse out
);

  // ****************************************************
  // register bus
  // ****************************************************

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [4:0] integ;
  logic [1:0] pol;

  // decode of one register index
  function automatic logic reg_hit(input logic [9:0] adr,
                                   input logic [7:0] idx);
    reg_hit = (adr[9:2] == idx);
  endfunction

  wire bus_req = cyc_i && stb_i && !ack_o;
  wire hit0 = reg_hit(adr_i, SYNC_CONTROL_ZERO_IDX);
  wire hit1 = reg_hit(adr_i, SYNC_CONTROL_ONE_IDX);
  wire wr0 = bus_req && we_i && sel_i[0] && hit0;
  wire wr1 = bus_req && we_i && sel_i[0] && hit1;

  // read views: status bits come from hardware
  wire [7:0] view0 = {ctrl0[7:5], integ};
  wire [7:0] view1 = {ctrl1[7:2], pol};
  wire [7:0] rd_byte = hit0 ? view0 : (hit1 ? view1 : 8'h00);

  // one wait state answer; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= bus_req;
      if (bus_req && !we_i)
      begin
        dat_o <= {24'h00_0000, rd_byte};
      end
    end
  end

  // writable fields only; read-only bits drop the write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl0 <= SYNC_CONTROL_ZERO_RST;
      ctrl1 <= SYNC_CONTROL_ONE_RST;
    end
    else
    begin
      if (wr0)
      begin
        ctrl0[7:5] <= dat_i[7:5];
      end
      if (wr1)
      begin
        ctrl1[7:2] <= dat_i[7:2];
      end
    end
  end

  wire input_source_select = ctrl0[INPUT_SOURCE_SELECT_BIT];
  wire hblank_en = ctrl0[HBLANK_ENABLE_BIT];
  wire vertical_output_source = ctrl0[VERTICAL_OUTPUT_SOURCE_BIT];
  wire [1:0] clamp_sel = ctrl1[CLAMP_SEL_HI_BIT:CLAMP_SEL_LO_BIT];
  wire porch = ctrl1[PORCH_MODE_BIT];
  wire clamp_pol = ctrl1[CLAMP_POLARITY_BIT];
  wire vinv = ctrl1[VERTICAL_OUTPUT_INVERT_BIT];
  wire hinv = ctrl1[HORIZONTAL_OUTPUT_INVERT_BIT];

  // ****************************************************
  // dividers
  // ****************************************************

  logic sample_phase;
  logic [9:0] pol_div;
  wire sample_tick = sample_phase;
  wire pol_tick = (pol_div == POL_TIMER_LAST);

  // sampling tick every second clock, polarity tick every thousandth
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sample_phase <= 1'b0;
      pol_div <= 10'h000;
    end
    else
    begin
      sample_phase <= !sample_phase;
      pol_div <= pol_tick ? 10'h000 : pol_div + 10'h001;
    end
  end

  // ****************************************************
  // sync selection and vertical separation
  // ****************************************************

  wire hsel = input_source_select ? csync_in_i : hsync_in_i;
  logic vsep;

  wire integ_full = (integ == INTEG_MAX);
  wire integ_empty = (integ == INTEG_MIN);
  wire [4:0] next_integ = !sample_tick ? integ :
                          (hsel ? (integ_full ? integ : integ + 5'h01) :
                           (integ_empty ? integ : integ - 5'h01));
  wire next_vsep = integ_full ? 1'b1 : (integ_empty ? 1'b0 : vsep);

  // saturating integrator and latched compare output
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      integ <= INTEG_MIN;
      vsep <= 1'b0;
    end
    else
    begin
      integ <= next_integ;
      vsep <= next_vsep;
    end
  end

  // ****************************************************
  // sync outputs
  // ****************************************************

  wire hblank = hblank_en && vertical_output_source && vsep;
  wire hproc = hblank ? 1'b0 : hsel;
  wire vproc = vertical_output_source ? vsep : vsync_in_i;
  wire next_hsync = hproc ^ hinv;
  wire next_vsync = vproc ^ vinv;

  // registered output drivers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hsync_o <= 1'b0;
      vsync_o <= 1'b0;
    end
    else
    begin
      hsync_o <= next_hsync;
      vsync_o <= next_vsync;
    end
  end

  // ****************************************************
  // clamp generator
  // ****************************************************

  vsp_clamp_state_type clamp_state;
  vsp_clamp_state_type next_clamp_state;
  logic hproc_d;
  logic [2:0] clamp_cnt;
  logic [2:0] clamp_last;

  wire rise = hproc && !hproc_d;
  wire fall = !hproc && hproc_d;
  wire clamp_trig = (porch ? fall : rise) && (clamp_sel != 2'b00);
  wire clamp_act = (clamp_state == CLAMP_PULSE);
  wire [2:0] width_last = (clamp_sel == 2'b01) ? CLAMP_W2_LAST :
                          (clamp_sel == 2'b10) ? CLAMP_W4_LAST :
                          CLAMP_W8_LAST;
  wire next_clamp = clamp_act ? clamp_pol : !clamp_pol;

  // pulse sequencer; edges during a pulse are ignored
  always_comb
  begin
    next_clamp_state = clamp_state;
    case (clamp_state)
      CLAMP_IDLE:
      begin
        if (clamp_trig)
        begin
          next_clamp_state = CLAMP_PULSE;
        end
      end
      CLAMP_PULSE:
      begin
        if (clamp_cnt == clamp_last)
        begin
          next_clamp_state = CLAMP_IDLE;
        end
      end
      default:
      begin
        next_clamp_state = CLAMP_IDLE;
      end
    endcase
  end

  // state, edge history, width count
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clamp_state <= CLAMP_IDLE;
      hproc_d <= 1'b0;
      clamp_cnt <= 3'h0;
      clamp_last <= 3'h0;
    end
    else
    begin
      clamp_state <= next_clamp_state;
      hproc_d <= hproc;
      clamp_cnt <= clamp_act ? clamp_cnt + 3'h1 : 3'h0;
      if (!clamp_act && clamp_trig)
      begin
        clamp_last <= width_last;
      end
    end
  end

  // clamp pin sits at its idle level when inhibited
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clamp_o <= 1'b1;
    end
    else
    begin
      clamp_o <= next_clamp;
    end
  end

  // ****************************************************
  // polarity detection
  // ****************************************************

  wire [1:0] pol_src = {vsync_in_i, hsync_in_i};

  // horizontal reading is raw input; composite input may mislead it
  generate
    for (genvar g = 0; g < 2; g++)
    begin : g_pol
      vsp_polarity u_pol (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(pol_tick),
        .level_i(pol_src[g]),
        .polarity_o(pol[g])
      );
    end
  endgenerate

  // ****************************************************
  // checks
  // ****************************************************

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_clamp_start(logic [1:0] mode);
    !clamp_act && clamp_trig && clamp_sel == mode;
  endsequence

  a_integ_count_up:
  assert property (sample_tick && hsel && !integ_full |=>
                   integ == $past(integ) + 5'h01)
    else $error("integrator did not count up");

  a_integ_hold_top:
  assert property (sample_tick && hsel && integ_full |=> integ_full)
    else $error("integrator wrapped at top");

  a_integ_count_down:
  assert property (sample_tick && !hsel && !integ_empty |=>
                   integ == $past(integ) - 5'h01)
    else $error("integrator did not count down");

  a_integ_one_step:
  assert property (!sample_tick |=> integ == $past(integ))
    else $error("integrator moved without a tick");

  a_vsep_latch:
  assert property ((integ_full |=> vsep) and (integ_empty |=> !vsep)
                   and (!integ_full && !integ_empty |=> $stable(vsep)))
    else $error("compare output wrong");

  a_vout_source:
  assert property (1'b1 |=> vsync_o ==
                   (($past(vertical_output_source) ? $past(vsep) :
                     $past(vsync_in_i)) ^ $past(vinv)))
    else $error("vertical output wrong");

  a_hout_shape:
  assert property (1'b1 |=> hsync_o ==
                   (($past(hblank) ? 1'b0 : $past(hsel)) ^ $past(hinv)))
    else $error("horizontal output wrong");

  a_clamp_two:
  assert property (s_clamp_start(2'b01) |=> clamp_act [*2] ##1 !clamp_act)
    else $error("clamp pulse not two cycles");

  a_clamp_four:
  assert property (s_clamp_start(2'b10) |=> clamp_act [*4] ##1 !clamp_act)
    else $error("clamp pulse not four cycles");

  a_clamp_eight:
  assert property (s_clamp_start(2'b11) |=> clamp_act [*8] ##1 !clamp_act)
    else $error("clamp pulse not eight cycles");

  a_clamp_edge_pick:
  assert property (!clamp_act && clamp_sel != 2'b00 &&
                   (porch ? fall : rise) |=> clamp_act)
    else $error("clamp did not start on selected edge");

  a_clamp_level:
  assert property (1'b1 |=> clamp_o == ($past(clamp_act) ~^ $past(clamp_pol)))
    else $error("clamp polarity wrong");

  a_status_ro:
  assert property (wr1 |=> pol == $past(pol) || $past(pol_tick))
    else $error("polarity bits took a write");

  a_status_view:
  assert property (bus_req && !we_i && hit0 |=> dat_o[4:0] == $past(integ))
    else $error("integrator value not readable");

endmodule
`default_nettype wire
